// File: logic/pfbo_host_ctrl.sv
// Host controller driving an asynchronous parallel NOR flash bus
//
// Summary of operation
// RULE1: Device latches commands with address and data
// RULE2: Command latch has no readable address
// RULE3: Read: select and gate low, strobe high
// RULE4: Write: strobe and select low, gate high
// RULE5: After reset, plain reads return array data
// RULE6: Array read persists until a write
// RULE7: Width select high gives sixteen data pins
// RULE8: Byte mode: top pin carries low address (host does so on reads; on writes it drives data bit 15)
// RULE9: Address bits 21..0, sector bits 21..15
// RULE10: Four-word pages, low bits pick word
// RULE11: Same-page reads use short latency
// RULE12: Bypass programs in two writes, else four
// RULE13: Erase one, several or all sectors
// RULE14: Buffer program holds 16 words/32 bytes
// RULE15: Lock pin low protects edge sector
// RULE16: Lock pin high follows group protection
// RULE17: Reset pulse aborts and returns to read
// RULE18: Gate high floats device data pins
// RULE19: Address at later fall, data earlier rise
// RULE20: Host never overlaps read and write strobes
`timescale 1ns/10ps
module pfbo_host_ctrl #(
  parameter logic [21:0] UNLOCK_ADDR1 = 22'h000555,
  parameter logic [21:0] UNLOCK_ADDR2 = 22'h0002AA,
  parameter logic [15:0] UNLOCK_DATA1 = 16'h00AA,
  parameter logic [15:0] UNLOCK_DATA2 = 16'h0055,
  parameter logic [15:0] PROGRAM_CMD  = 16'h00A0
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  // Register port
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [31:0] o_reg_rdata,
  // Flash control pins
  output logic [21:0]      o_addr,
  output logic             o_chip_select_n,
  output logic             o_output_gate_n,
  output logic             o_write_strobe_n,
  output logic             o_hw_reset_n,
  output logic             o_width_select_n,
  output logic             o_edge_sector_lock_n,
  // Flash data pins
  input  wire logic [15:0] i_dq,
  output logic      [15:0] o_dq,
  output logic      [15:0] o_dq_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  pfbo_pkg::pfbo_state_e st, next_st;
  logic [2:0]  cfg, next_cfg;
  logic [22:0] addr, next_addr;
  logic [15:0] wdata, next_wdata;
  logic [15:0] rdata, next_rdata;
  logic        err, next_err;
  logic        pg_valid, next_pg_valid;
  logic [19:0] pg_tag, next_pg_tag;
  logic        rd_hit, next_rd_hit;
  logic [1:0]  seq, next_seq;
  logic        buf_op, next_buf_op;
  logic [5:0]  buf_cnt, next_buf_cnt;
  logic [31:0] next_rdout;
  logic [21:0] next_pin_addr;
  logic        next_cs_n, next_oe_n, next_we_n, next_rst_n;
  logic [15:0] next_dq, next_dq_oe;
  logic        t_load, t_done;
  logic [7:0]  t_val;
  logic [15:0] dq_sync;
  logic        cmd_go;
  logic [2:0]  cmd_op;
  logic        byte_m;
  logic [5:0]  buf_lim;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Address of step idx of a write sequence
  function automatic logic [21:0] seq_addr(input logic [1:0] idx, input logic [21:0] a);
    case (idx)
      2'b00:   seq_addr = UNLOCK_ADDR1;
      2'b01:   seq_addr = UNLOCK_ADDR2;
      2'b10:   seq_addr = UNLOCK_ADDR1;
      default: seq_addr = a;
    endcase
  endfunction

  // Data of step idx of a write sequence
  function automatic logic [15:0] seq_data(input logic [1:0] idx, input logic [15:0] d);
    case (idx)
      2'b00:   seq_data = UNLOCK_DATA1;
      2'b01:   seq_data = UNLOCK_DATA2;
      2'b10:   seq_data = PROGRAM_CMD;
      default: seq_data = d;
    endcase
  endfunction

  // Data lanes the host drives during a write strobe
  function automatic logic [15:0] lane_mask(input logic bm);
    lane_mask = bm ? pfbo_pkg::MASK_BYTE : pfbo_pkg::MASK_WORD;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Submodules
  pfbo_pin_sync #(.W(16)) pfbo_pin_sync_i (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_pin      (i_dq),
    .o_sync     (dq_sync)
  );

  pfbo_wait_timer #(.W(pfbo_pkg::TMR_W), .RST_VAL(pfbo_pkg::RST_LOW_WAIT)) pfbo_wait_timer_i (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_load     (t_load),
    .i_val      (t_val),
    .o_done     (t_done)
  );

  assign cmd_go  = i_reg_wr && (i_reg_addr == pfbo_pkg::REG_CMD);
  assign cmd_op  = i_reg_wdata[2:0];
  assign byte_m  = cfg[pfbo_pkg::CFG_BYTE];
  assign buf_lim = byte_m ? pfbo_pkg::BUF_MAX_BYTES : pfbo_pkg::BUF_MAX_WORDS;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: registers and bus sequencer
  always_comb begin
    next_st = st;  next_cfg = cfg;  next_addr = addr;  next_wdata = wdata;
    next_rdata = rdata;  next_err = err;  next_pg_valid = pg_valid;
    next_pg_tag = pg_tag;  next_rd_hit = rd_hit;  next_seq = seq;
    next_buf_op = buf_op;  next_buf_cnt = buf_cnt;  next_rdout = '0;
    next_pin_addr = o_addr;  next_cs_n = o_chip_select_n;
    next_oe_n = o_output_gate_n;  next_we_n = o_write_strobe_n;
    next_rst_n = o_hw_reset_n;  next_dq = o_dq;  next_dq_oe = o_dq_oe;
    t_load = 1'b0;  t_val = '0;
    // Register writes; error bit is write-one-to-clear
    if (i_reg_wr) begin
      case (i_reg_addr)
        pfbo_pkg::REG_CFG:   next_cfg = i_reg_wdata[2:0];
        pfbo_pkg::REG_ADDR:  next_addr = i_reg_wdata[22:0];
        pfbo_pkg::REG_WDATA: next_wdata = i_reg_wdata[15:0];
        pfbo_pkg::REG_STAT:  if (i_reg_wdata[pfbo_pkg::STAT_ERR]) next_err = 1'b0;
        default: ;
      endcase
    end
    // Register reads, answered next cycle only
    if (i_reg_rd) begin
      case (i_reg_addr)
        pfbo_pkg::REG_CFG:   next_rdout = {29'h0, cfg};
        pfbo_pkg::REG_ADDR:  next_rdout = {9'h0, addr};
        pfbo_pkg::REG_WDATA: next_rdout = {16'h0, wdata};
        pfbo_pkg::REG_RDATA: next_rdout = {16'h0, rdata};
        pfbo_pkg::REG_STAT:  next_rdout = {18'h0, buf_cnt, 5'h0, pg_valid, err, (st != pfbo_pkg::S_IDLE)};
        default:             next_rdout = '0;
      endcase
    end
    // Commands while busy are refused; set wins over clear
    if (cmd_go && (st != pfbo_pkg::S_IDLE)) next_err = 1'b1;
    case (st)
      pfbo_pkg::S_IDLE: begin
        if (cmd_go) begin
          case (cmd_op)
            pfbo_pkg::OP_READ: begin
              next_pin_addr = addr[21:0];                                       // RULE9
              next_dq[15]   = addr[pfbo_pkg::A_LOW_BIT];                        // RULE8
              next_dq_oe    = pfbo_pkg::MASK_KEEP;                              // RULE20
              next_pg_tag   = addr[21:pfbo_pkg::PAGE_LSB];                      // RULE10
              next_pg_valid = 1'b1;
              next_cs_n     = 1'b0;
              if (pg_valid && !o_chip_select_n && (pg_tag == addr[21:pfbo_pkg::PAGE_LSB])) begin
                next_rd_hit = 1'b1;                                             // RULE11
                t_load      = 1'b1;
                t_val       = pfbo_pkg::RD_PAGE_WAIT;
                next_st     = pfbo_pkg::S_RD_WAIT;
              end else begin
                next_rd_hit = 1'b0;
                next_oe_n   = 1'b1;
                next_st     = pfbo_pkg::S_RD_SET;
              end
            end
            pfbo_pkg::OP_WRITE, pfbo_pkg::OP_PROG, pfbo_pkg::OP_BUFLD: begin
              if ((cmd_op == pfbo_pkg::OP_BUFLD) && (buf_cnt == buf_lim)) begin
                next_err = 1'b1;                                                // RULE14
              end else begin
                // Bypass skips the two unlock cycles
                next_seq      = (cmd_op != pfbo_pkg::OP_PROG) ? 2'b11 :
                                (cfg[pfbo_pkg::CFG_BYPASS] ? 2'b10 : 2'b00);    // RULE12
                next_buf_op   = (cmd_op == pfbo_pkg::OP_BUFLD);
                next_pin_addr = seq_addr(next_seq, addr[21:0]);
                next_dq       = seq_data(next_seq, wdata);
                next_oe_n     = 1'b1;                                           // RULE4
                next_cs_n     = 1'b1;
                next_dq_oe    = o_output_gate_n ? lane_mask(byte_m) : pfbo_pkg::MASK_KEEP; // RULE20
                next_pg_valid = 1'b0;
                next_st       = pfbo_pkg::S_WR_SET;
              end
            end
            pfbo_pkg::OP_RESET: begin
              next_rst_n = 1'b0;                                                // RULE17
              next_cs_n  = 1'b1;
              next_oe_n  = 1'b1;
              next_dq_oe = pfbo_pkg::MASK_KEEP;
              t_load     = 1'b1;
              t_val      = pfbo_pkg::RST_LOW_WAIT;
              next_st    = pfbo_pkg::S_RST_LOW;
            end
            default: next_err = 1'b1;
          endcase
        end
      end
      pfbo_pkg::S_RD_SET: begin
        next_oe_n = 1'b0;                                                       // RULE3
        t_load    = 1'b1;
        t_val     = pfbo_pkg::RD_FULL_WAIT;                                     // RULE11
        next_st   = pfbo_pkg::S_RD_WAIT;
      end
      pfbo_pkg::S_RD_WAIT: begin
        next_oe_n = 1'b0;
        if (t_done) begin
          next_rdata = byte_m ? {8'h00, dq_sync[7:0]} : dq_sync;                // RULE7
          next_st    = pfbo_pkg::S_IDLE;
        end
      end
      pfbo_pkg::S_WR_SET: begin
        // Address settles before the strobe falls
        next_cs_n  = 1'b0;                                                      // RULE19
        next_we_n  = 1'b0;
        next_dq_oe = lane_mask(byte_m);
        t_load     = 1'b1;
        t_val      = pfbo_pkg::WE_LOW_WAIT;
        next_st    = pfbo_pkg::S_WR_LOW;
      end
      pfbo_pkg::S_WR_LOW: begin
        if (t_done) begin
          next_we_n = 1'b1;                                                     // RULE19
          next_cs_n = 1'b1;
          next_st   = pfbo_pkg::S_WR_HOLD;
        end
      end
      pfbo_pkg::S_WR_HOLD: begin
        if (seq != 2'b11) begin
          next_seq      = seq + 2'b01;
          next_pin_addr = seq_addr(next_seq, addr[21:0]);
          next_dq       = seq_data(next_seq, wdata);
          next_st       = pfbo_pkg::S_WR_SET;
        end else begin
          next_dq_oe   = pfbo_pkg::MASK_KEEP;
          next_buf_cnt = buf_op ? buf_cnt + 6'h01 : 6'h00;                      // RULE14
          next_st      = pfbo_pkg::S_IDLE;
        end
      end
      pfbo_pkg::S_RST_LOW: begin
        if (t_done) begin
          next_rst_n = 1'b1;
          t_load     = 1'b1;
          t_val      = pfbo_pkg::RST_REC_WAIT;
          next_st    = pfbo_pkg::S_RST_REC;
        end
      end
      pfbo_pkg::S_RST_REC: begin
        if (t_done) begin
          next_pg_valid = 1'b0;
          next_buf_cnt  = '0;
          next_st       = pfbo_pkg::S_IDLE;                                     // RULE5
        end
      end
      default: next_st = pfbo_pkg::S_IDLE;
    endcase
    // Byte mode: upper lanes float, top lane carries the low address bit on reads and data bit 15 on writes
    if (next_cfg[pfbo_pkg::CFG_BYTE]) begin
      next_dq_oe[14:8] = 7'h00;                                                 // RULE8
      next_dq_oe[15]   = 1'b1;
    end else if (!o_write_strobe_n || (next_st == pfbo_pkg::S_WR_LOW)) begin
      next_dq_oe[15]   = 1'b1;
    end else if (st == pfbo_pkg::S_IDLE || st == pfbo_pkg::S_RD_SET || st == pfbo_pkg::S_RD_WAIT) begin
      next_dq_oe[15]   = 1'b0;                                                  // RULE7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers; the flash starts in a reset pulse
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= pfbo_pkg::S_RST_LOW;  cfg <= '0;  addr <= '0;  wdata <= '0;
      rdata <= '0;  err <= 1'b0;  pg_valid <= 1'b0;  pg_tag <= '0;
      rd_hit <= 1'b0;  seq <= '0;  buf_op <= 1'b0;  buf_cnt <= '0;
      o_reg_rdata <= '0;  o_addr <= '0;  o_chip_select_n <= 1'b1;
      o_output_gate_n <= 1'b1;  o_write_strobe_n <= 1'b1;  o_hw_reset_n <= 1'b0;
      o_width_select_n <= 1'b1;  o_edge_sector_lock_n <= 1'b1;
      o_dq <= '0;  o_dq_oe <= '0;
    end else begin
      st <= next_st;  cfg <= next_cfg;  addr <= next_addr;  wdata <= next_wdata;
      rdata <= next_rdata;  err <= next_err;  pg_valid <= next_pg_valid;
      pg_tag <= next_pg_tag;  rd_hit <= next_rd_hit;  seq <= next_seq;
      buf_op <= next_buf_op;  buf_cnt <= next_buf_cnt;  o_reg_rdata <= next_rdout;
      o_addr <= next_pin_addr;  o_chip_select_n <= next_cs_n;
      o_output_gate_n <= next_oe_n;  o_write_strobe_n <= next_we_n;
      o_hw_reset_n <= next_rst_n;
      o_width_select_n <= ~next_cfg[pfbo_pkg::CFG_BYTE];                       // RULE7
      o_edge_sector_lock_n <= ~next_cfg[pfbo_pkg::CFG_LOCK];                   // RULE15
      o_dq <= next_dq;  o_dq_oe <= next_dq_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [7:0] rst_low_cnt;
  logic [2:0] we_falls;

  // Counts reset low cycles and strobe falls per command
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_low_cnt <= '0;
      we_falls    <= '0;
    end else begin
      rst_low_cnt <= o_hw_reset_n ? 8'h00 : rst_low_cnt + 8'h01;
      if (st == pfbo_pkg::S_IDLE) we_falls <= '0;
      else if (next_st == pfbo_pkg::S_WR_LOW && st == pfbo_pkg::S_WR_SET) we_falls <= we_falls + 3'h1;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  read_no_strobe_a: assert property (!o_output_gate_n |-> o_write_strobe_n) // RULE3
    else $error("read gate low while write strobe low");
  write_gate_high_a: assert property (!o_write_strobe_n |-> o_output_gate_n && !o_chip_select_n) // RULE4
    else $error("write strobe without select or with gate low");
  read_no_drive_a: assert property (!o_output_gate_n |-> o_dq_oe[14:0] == 15'h0000) // RULE20
    else $error("host drives data lanes during read");
  byte_lanes_a: assert property (!o_width_select_n |-> o_dq_oe[14:8] == 7'h00 && o_dq_oe[15]) // RULE8
    else $error("byte mode lane enables wrong");
  reset_width_a: assert property ($rose(o_hw_reset_n) |-> rst_low_cnt >= pfbo_pkg::RST_LOW_WAIT) // RULE17
    else $error("hardware reset pulse too short");
  page_stable_a: assert property (st == pfbo_pkg::S_RD_WAIT && t_done && rd_hit // RULE11
                                  |-> $past(o_addr, 3) == o_addr)
    else $error("page read sampled too early");
  full_access_a: assert property (st == pfbo_pkg::S_RD_WAIT && t_done && !rd_hit // RULE11
                                  |-> !$past(o_output_gate_n, 6) && $past(o_addr, 6) == o_addr)
    else $error("random read sampled too early");
  prog_cycles_a: assert property (st == pfbo_pkg::S_WR_HOLD && seq == 2'b11 && next_st == pfbo_pkg::S_IDLE // RULE12
                                  && we_falls != 3'h1
                                  |-> we_falls == (cfg[pfbo_pkg::CFG_BYPASS] ? 3'h2 : 3'h4))
    else $error("program sequence cycle count wrong");
  buf_limit_a: assert property (buf_cnt <= pfbo_pkg::BUF_MAX_BYTES) // RULE14
    else $error("write buffer count over limit");
  addr_hold_a: assert property (!o_write_strobe_n && !$past(o_write_strobe_n) // RULE19
                                |-> $stable(o_addr) && $stable(o_dq))
    else $error("address or data moved during write strobe");

endmodule // pfbo_host_ctrl

// File: logic/pfbo_pin_sync.sv
// Two-flop synchroniser for the flash data pins
`timescale 1ns/10ps
module pfbo_pin_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_arst_n,
  // Pin side and synchronised side
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_pin;
      o_sync <= meta;
    end
  end

endmodule // pfbo_pin_sync

// File: logic/pfbo_pkg.sv
// Constants, register map and types of the parallel flash host controller
package pfbo_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and bus timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_RANDOM_NS   = 90;   // random_access_latency
  localparam int T_PAGE_NS     = 25;   // intra_page_latency
  localparam int T_WE_LOW_NS   = 35;   // write strobe low width
  localparam int T_RST_LOW_NS  = 500;  // hardware reset pulse width
  localparam int T_RST_REC_NS  = 50;   // reset high time before first access

  // Least time rounded up to whole cycles, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SYNC_STAGES  = 2;
  localparam int TMR_W        = 8;
  localparam int RANDOM_CYC   = ns_to_cyc(T_RANDOM_NS);
  localparam int PAGE_CYC     = ns_to_cyc(T_PAGE_NS);
  localparam logic [TMR_W-1:0] RD_FULL_WAIT = TMR_W'(RANDOM_CYC + SYNC_STAGES);
  localparam logic [TMR_W-1:0] RD_PAGE_WAIT = TMR_W'(PAGE_CYC + SYNC_STAGES);
  localparam logic [TMR_W-1:0] WE_LOW_WAIT  = TMR_W'(ns_to_cyc(T_WE_LOW_NS));
  localparam logic [TMR_W-1:0] RST_LOW_WAIT = TMR_W'(ns_to_cyc(T_RST_LOW_NS));
  localparam logic [TMR_W-1:0] RST_REC_WAIT = TMR_W'(ns_to_cyc(T_RST_REC_NS));

  ////////////////////////////////////////////////////////////////////////////
  // Flash geometry
  localparam int ADDR_W    = 22;
  localparam int DATA_W    = 16;
  localparam int PAGE_LSB  = 2;
  localparam int BUF_W     = 6;
  localparam logic [BUF_W-1:0] BUF_MAX_WORDS = 6'h10;
  localparam logic [BUF_W-1:0] BUF_MAX_BYTES = 6'h20;
  localparam logic [DATA_W-1:0] MASK_WORD  = 16'hFFFF;
  localparam logic [DATA_W-1:0] MASK_BYTE  = 16'h80FF;
  localparam logic [DATA_W-1:0] MASK_KEEP  = 16'h8000;

  ////////////////////////////////////////////////////////////////////////////
  // Register map of the controller
  localparam logic [3:0] REG_CMD   = 4'h0;
  localparam logic [3:0] REG_CFG   = 4'h1;
  localparam logic [3:0] REG_ADDR  = 4'h2;
  localparam logic [3:0] REG_WDATA = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_STAT  = 4'h5;
  localparam int CFG_BYTE   = 0;
  localparam int CFG_LOCK   = 1;
  localparam int CFG_BYPASS = 2;
  localparam int STAT_BUSY  = 0;
  localparam int STAT_ERR   = 1;
  localparam int STAT_PAGE  = 2;
  localparam int STAT_BUF   = 8;
  localparam int A_LOW_BIT  = 22;   // byte-mode low address bit in REG_ADDR

  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_READ  = 3'b001,
    OP_WRITE = 3'b010,
    OP_PROG  = 3'b011,
    OP_BUFLD = 3'b100,
    OP_RESET = 3'b101
  } pfbo_op_e;

  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_RD_SET  = 3'b001,
    S_RD_WAIT = 3'b010,
    S_WR_SET  = 3'b011,
    S_WR_LOW  = 3'b100,
    S_WR_HOLD = 3'b101,
    S_RST_LOW = 3'b110,
    S_RST_REC = 3'b111
  } pfbo_state_e;

endpackage

// File: logic/pfbo_wait_timer.sv
// Down counter that times bus phases in core clock cycles
`timescale 1ns/10ps
module pfbo_wait_timer #(
  parameter int               W       = 8,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_arst_n,
  // Load and status
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_val,
  output logic              o_done
);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  // Load wins, else count down to zero
  always_comb begin
    next_cnt = cnt;
    if (i_load) begin
      next_cnt = i_val;
    end else if (cnt != '0) begin
      next_cnt = cnt - W'(1);
    end
  end

  // Counter register
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt <= RST_VAL;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign o_done = (cnt == '0);

endmodule // pfbo_wait_timer

// File: sim/parallel_flash_bus_operations_test.sv
// Self-checking bench for the parallel flash host controller
`timescale 1ns/10ps
module parallel_flash_bus_operations_test;
  logic i_core_clk, i_arst_n, i_reg_wr, i_reg_rd;
  logic [3:0] i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata, rv;
  logic [21:0] addr;
  logic cs_n, oe_n, we_n, rst_n, byte_n, lock_n;
  logic [15:0] h_dq, h_oe, m_dq, m_oe, dq_w, last;
  int mismatches, total_checks, wcnt;
  // Clock
  initial begin
    i_core_clk = 0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  // Shared pin level; floating lanes show the inverse of the last value
  assign dq_w = (h_oe & h_dq) | (~h_oe & m_oe & m_dq) | (~h_oe & ~m_oe & ~last);
  always @(posedge i_core_clk) last <= dq_w;
  always @(negedge we_n) wcnt++;
  pfbo_host_ctrl pfbo_host_ctrl_i (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_addr(addr), .o_chip_select_n(cs_n), .o_output_gate_n(oe_n), .o_write_strobe_n(we_n),
    .o_hw_reset_n(rst_n), .o_width_select_n(byte_n), .o_edge_sector_lock_n(lock_n), .i_dq(dq_w),
    .o_dq(h_dq), .o_dq_oe(h_oe));
  pfbo_flash_model pfbo_flash_model_i (.i_addr(addr), .i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n),
    .i_rst_n(rst_n), .i_byte_n(byte_n), .i_lock_n(lock_n), .i_dq(dq_w), .o_dq(m_dq), .o_oe(m_oe));
  ////////////////////////////////////////////////////////////////////////////
  // Bus and compare tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_reg_wr <= 1'b1; i_reg_addr <= a; i_reg_wdata <= d;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    i_reg_rd <= 1'b1; i_reg_addr <= a;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin rd(pfbo_pkg::REG_STAT, rv); n++; end while (rv[0] !== 1'b0 && n < 200);
    if (n >= 200) chk(32'h0000_0000, 32'h0000_0001);
  endtask
  task automatic flash_read(input logic [31:0] a, input logic [31:0] exp);
    wr(pfbo_pkg::REG_ADDR, a);
    wr(pfbo_pkg::REG_CMD, 32'h1);
    wait_idle();
    rd(pfbo_pkg::REG_RDATA, rv);
    chk(rv, exp);
  endtask
  task automatic flash_program(input logic [2:0] cfg, input logic [21:0] a, input int strobes);
    wr(pfbo_pkg::REG_CFG, {29'h0, cfg});
    wr(pfbo_pkg::REG_ADDR, {10'h0, a});
    wr(pfbo_pkg::REG_WDATA, 32'h0F0F);
    wcnt = 0;
    wr(pfbo_pkg::REG_CMD, 32'h3);
    wait_idle();
    chk(wcnt, strobes);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reads();
    flash_read(32'h10, 32'hC310);
    flash_read(32'h12, 32'hC312);
    flash_read(32'h40, 32'hC340);
  endtask
  task automatic t_program();
    flash_program(3'h4, 22'h008003, 2);
    flash_read(32'h008003, 32'h0303);
    flash_program(3'h0, 22'h008006, 4);
    flash_read(32'h008006, 32'h0306);
    flash_program(3'h2, 22'h000005, 4);
    chk(lock_n, 1'b0);
    wr(pfbo_pkg::REG_CFG, 32'h0);
    flash_read(32'h000005, 32'hC305);
  endtask
  task automatic t_byte();
    wr(pfbo_pkg::REG_CFG, 32'h1);
    flash_read(32'h0040_0021, 32'h00C3);
    chk(h_oe, 16'h8000);
    chk(h_dq[15], 1'b1);
    chk(byte_n, 1'b0);
    flash_read(32'h0000_0022, 32'h0022);
    wr(pfbo_pkg::REG_CFG, 32'h0);
  endtask
  task automatic t_buffer();
    wr(pfbo_pkg::REG_CMD, 32'h2);
    wait_idle();
    for (int i = 0; i < 17; i++) begin
      wr(pfbo_pkg::REG_CMD, 32'h4);
      wait_idle();
    end
    rd(pfbo_pkg::REG_STAT, rv);
    chk(rv & 32'h3F03, 32'h1002);
    wr(pfbo_pkg::REG_STAT, 32'h2);
    rd(4'hF, rv);
    chk(rv, 32'h0);
    wr(pfbo_pkg::REG_CMD, 32'h7);
    rd(pfbo_pkg::REG_STAT, rv);
    chk(rv[1:0], 2'b10);
    wr(pfbo_pkg::REG_STAT, 32'h2);
  endtask
  task automatic t_reset();
    wr(pfbo_pkg::REG_CMD, 32'h5);
    @(posedge i_core_clk);
    #1 chk(rst_n, 1'b0);
    chk(h_oe, 16'h0000);
    wait_idle();
    flash_read(32'h008003, 32'h0303);
  endtask
  task automatic t_erase();
    flash_program(3'h0, 22'h000005, 4);
    flash_read(32'h000005, 32'h0305);
    wr(pfbo_pkg::REG_CFG, 32'h2);
    wr(pfbo_pkg::REG_WDATA, 32'h0030);
    wr(pfbo_pkg::REG_CMD, 32'h2);
    wait_idle();
    flash_read(32'h000005, 32'h0305);
    wr(pfbo_pkg::REG_CFG, 32'h0);
    wr(pfbo_pkg::REG_CMD, 32'h2);
    wait_idle();
    flash_read(32'h008003, 32'hFFFF);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Verdict
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #(25 * 40000);
    mismatches++;
    print_verdict();
  end
  // Main sequence
  initial begin
    i_arst_n = 0; i_reg_wr = 0; i_reg_rd = 0; i_reg_addr = '0; i_reg_wdata = '0;
    mismatches = 0; total_checks = 0; wcnt = 0; last = '0;
    repeat (20) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    wait_idle();
    t_reads();
    t_program();
    t_byte();
    t_buffer();
    t_reset();
    t_erase();
    print_verdict();
  end
endmodule // parallel_flash_bus_operations_test

// File: sim/pfbo_flash_model.sv
// Behavioural parallel NOR flash answering the host controller
`timescale 1ns/10ps
module pfbo_flash_model #(
  parameter logic [15:0] PROGRAM_CMD = 16'h00A0,
  parameter logic [15:0] ERASE_CMD   = 16'h0030,
  parameter int          LAT_NS      = 20
) (
  // Bus pins
  input  wire logic [21:0] i_addr,
  input  wire logic        i_cs_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic        i_rst_n,
  input  wire logic        i_byte_n,
  input  wire logic        i_lock_n,
  input  wire logic [15:0] i_dq,
  output logic      [15:0] o_dq,
  output logic      [15:0] o_oe
);
  logic [15:0] mem [0:255];
  logic [15:0] cmd_latch;
  logic [21:0] wr_addr;
  logic [15:0] word;
  logic        rd_en;
  wire         wstb = i_cs_n | i_we_n;
  // Array preset, small window indexed by low address bits
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = {8'hC3, 8'(i)};
    cmd_latch = '0;
  end
  // Address on the later fall, data on the earlier rise
  always @(negedge wstb) if (i_rst_n) wr_addr = i_addr;
  always @(posedge wstb) begin
    if (i_rst_n) begin
      if (cmd_latch == PROGRAM_CMD && !(!i_lock_n && wr_addr[21:15] == 7'h00))
        mem[wr_addr[7:0]] = mem[wr_addr[7:0]] & i_dq;
      // Erase code wipes the window, onto which every sector aliases
      if (i_dq == ERASE_CMD && !(!i_lock_n && wr_addr[21:15] == 7'h00))
        for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
      cmd_latch = i_dq;
    end
  end
  // Reset pulse drops the latch back to array read
  always @(negedge i_rst_n) cmd_latch = '0;
  // Array data only, never the latch; byte lane by top pin
  assign rd_en = !i_cs_n && !i_oe_n && i_we_n && i_rst_n;
  assign word  = mem[i_addr[7:0]];
  assign #(LAT_NS) o_dq = i_byte_n ? word : {8'h00, i_dq[15] ? word[15:8] : word[7:0]};
  assign o_oe = !rd_en ? 16'h0000 : (i_byte_n ? 16'hFFFF : 16'h00FF);
endmodule // pfbo_flash_model
